//--- src/xema_params.svh
// Constants for the external data memory access block
`ifndef XEMA_PARAMS_SVH
`define XEMA_PARAMS_SVH
`define XEMA_REG_PAGE 8'h00
`define XEMA_REG_CFG 8'h01
`define XEMA_REG_PTRH 8'h02
`define XEMA_REG_PTRL 8'h03
`define XEMA_REG_FLCTL 8'h04
`define XEMA_REG_STAT 8'h05
`define XEMA_CFG_RESET 8'h03
`define XEMA_CFG_WMASK 8'h5F
`define XEMA_CFG_FIFO_BIT 6
`define XEMA_CFG_NONMUX_BIT 4
`define XEMA_CFG_MODE_HI 3
`define XEMA_CFG_MODE_LO 2
`define XEMA_CFG_ALE_HI 1
`define XEMA_CFG_ALE_LO 0
`define XEMA_FLCTL_WE_BIT 0
`define XEMA_MODE_ONCHIP 2'h0
`define XEMA_MODE_SPLIT 2'h1
`define XEMA_MODE_SPLIT_BANK 2'h2
`define XEMA_MODE_OFFCHIP 2'h3
`define XEMA_FIFO_LO 16'h0400
`define XEMA_FIFO_HI 16'h07FF
`define XEMA_RAM_BYTES_4K 4096
`define XEMA_RAM_BYTES_2K 2048
`define XEMA_STROBE_CYC 4
`define XEMA_HOLD_CYC 1
`define XEMA_FIFO_MIN_CYC 3
`endif

//--- src/xema_pkg.sv
// Types shared by the external data memory access block
package xema_pkg;
  typedef enum logic [3:0] {
    XEMA_TGT_RAM = 4'b0001,
    XEMA_TGT_FIFO = 4'b0010,
    XEMA_TGT_EXT = 4'b0100,
    XEMA_TGT_FLASH = 4'b1000
  } xema_tgt_t;

  typedef struct packed {
    logic wr;
    logic wide;
    logic [7:0] index;
    logic [7:0] wdata;
  } xema_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic addr_oe;
    logic [7:0] data;
    logic data_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic ctl_oe;
  } xema_pins_t;
endpackage : xema_pkg

//--- src/xema_ext_mem_iface_seq.sv
// Off-chip bus cycle sequencer driving the external interface pins
`timescale 1ns/1ps
`include "xema_params.svh"
module xema_xbus_seq #(
  parameter int STROBE_CYC = `XEMA_STROBE_CYC,
  parameter int HOLD_CYC = `XEMA_HOLD_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Cycle request
  input wire logic start_in,
  input wire logic wr_in,
  input wire logic mux_in,
  input wire logic [1:0] ale_cyc_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  // Pins and result
  input wire logic [7:0] data_pin_in,
  output xema_pkg::xema_pins_t pins_out,
  output logic done_out,
  output logic [7:0] rdata_out
);
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_ALE = 4'b0010,
    E_STRB = 4'b0100,
    E_HOLD = 4'b1000
  } xema_eph_t;

  xema_eph_t ph_q;
  logic [3:0] cnt_q;
  logic wr_q;
  logic [7:0] wdata_q;

  // Pin ownership only from start to end of the bus cycle
  always_ff @(posedge core_clk_in)
  begin
    done_out <= 1'b0;
    if (rst_in)
    begin
      ph_q <= E_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      pins_out <= '{addr: 16'h0000, addr_oe: 1'b0, data: 8'h00, data_oe: 1'b0,
                    ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ctl_oe: 1'b0};
      rdata_out <= 8'h00;
    end
    else
    begin
      unique case (ph_q)
        E_IDLE:
          if (start_in)
          begin
            wr_q <= wr_in;
            wdata_q <= wdata_in;
            pins_out.addr <= addr_in;
            pins_out.addr_oe <= 1'b1;
            pins_out.ctl_oe <= 1'b1;
            if (mux_in)
            begin
              pins_out.data <= addr_in[7:0];
              pins_out.data_oe <= 1'b1;
              pins_out.ale <= 1'b1;
              cnt_q <= {2'b00, ale_cyc_in};
              ph_q <= E_ALE;
            end
            else
            begin
              pins_out.data <= wdata_in;
              pins_out.data_oe <= wr_in;
              pins_out.rd_n <= wr_in;
              pins_out.wr_n <= ~wr_in;
              cnt_q <= 4'(STROBE_CYC - 1);
              ph_q <= E_STRB;
            end
          end
        E_ALE:
          if (cnt_q == 4'h0)
          begin
            pins_out.ale <= 1'b0;
            pins_out.data <= wdata_q;
            pins_out.data_oe <= wr_q;
            pins_out.rd_n <= wr_q;
            pins_out.wr_n <= ~wr_q;
            cnt_q <= 4'(STROBE_CYC - 1);
            ph_q <= E_STRB;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        E_STRB:
          if (cnt_q == 4'h0)
          begin
            if (!wr_q)
              rdata_out <= data_pin_in;
            pins_out.rd_n <= 1'b1;
            pins_out.wr_n <= 1'b1;
            cnt_q <= 4'(HOLD_CYC - 1);
            ph_q <= E_HOLD;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        E_HOLD:
          if (cnt_q == 4'h0)
          begin
            // Drop every enable so the port latches take the pins back
            pins_out.addr_oe <= 1'b0;
            pins_out.data_oe <= 1'b0;
            pins_out.ctl_oe <= 1'b0;
            done_out <= 1'b1;
            ph_q <= E_IDLE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
      endcase
    end
  end

  // Only enables leave this block; drive type stays with the port mode registers

  chk_pins_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    done_out |-> !pins_out.addr_oe && !pins_out.data_oe && !pins_out.ctl_oe)
    else $error("pins still owned after bus cycle");
  chk_read_float: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!wr_q && !pins_out.rd_n) |-> !pins_out.data_oe)
    else $error("data driven during read strobe");
endmodule : xema_xbus_seq

//--- src/xema_access.sv
// External data space access: address forming, decode, RAM, FIFO, flash and off-chip
// Summary of operation
// - On-chip RAM of 4k or 2k bytes sits in external data space.
// - Wide form uses the whole 16-bit data pointer as address.
// - Short form takes high byte from page register, low byte from index.
// - Data pointer is read and written as separate high and low bytes.
// - Accesses go to data space, except writes while flash writing is enabled, which go to flash.
// - With window mapping on, 0x0400 to 0x07FF reach the USB FIFO RAM.
// - With window mapping on, normal memory in that range is unreachable.
// - FIFO window accesses take more cycles than ordinary RAM accesses.
// - Interface owns pins only during an off-chip access, then releases.
// - Pins acting as inputs have drivers off during the access.
// - Push-pull or open-drain choice is untouched by the interface.
// - Multiplexed and separate buses, four memory modes are supported.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "xema_params.svh"
module xema_access #(
  parameter int RAM_BYTES = `XEMA_RAM_BYTES_4K,
  parameter int STROBE_CYC = `XEMA_STROBE_CYC,
  parameter int HOLD_CYC = `XEMA_HOLD_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Access request from the core
  input wire logic req_in,
  input wire xema_pkg::xema_req_t req_data_in,
  output logic done_out,
  output logic busy_out,
  output logic [7:0] rdata_out,
  // FIFO RAM handshake
  output logic fifo_req_out,
  output logic fifo_wr_out,
  output logic [9:0] fifo_addr_out,
  output logic [7:0] fifo_wdata_out,
  input wire logic fifo_ack_in,
  input wire logic [7:0] fifo_rdata_in,
  // Flash write path
  output logic flash_wr_out,
  output logic [15:0] flash_addr_out,
  output logic [7:0] flash_data_out,
  // External interface pins
  input wire logic [7:0] data_pin_in,
  output xema_pkg::xema_pins_t pins_out
);
  localparam int RAW = $clog2(RAM_BYTES);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_FIFO = 4'b0010,
    S_EXT = 4'b0100,
    S_RESP = 4'b1000
  } xema_st_t;

  xema_st_t st_q;
  logic [7:0] page_q;
  logic [7:0] cfg_q;
  logic [7:0] ptr_hi_q;
  logic [7:0] ptr_lo_q;
  logic flash_en_q;
  logic [15:0] addr_q;
  xema_pkg::xema_req_t req_q;
  xema_pkg::xema_tgt_t tgt_q;
  logic [7:0] ram_q [RAM_BYTES];
  logic ext_start_q;
  logic ext_done;
  logic [7:0] ext_rdata;
  logic accept;
  logic [15:0] acc_addr;
  xema_pkg::xema_tgt_t acc_tgt;

  // Effective address of either instruction form
  function automatic logic [15:0] eff_addr(input xema_pkg::xema_req_t r,
                                           input logic [7:0] hi_ptr,
                                           input logic [7:0] lo_ptr,
                                           input logic [7:0] page);
    if (r.wide)
      eff_addr = {hi_ptr, lo_ptr};
    else
      eff_addr = {page, r.index};
  endfunction : eff_addr

  // Target decode by window, flash enable and memory mode
  function automatic xema_pkg::xema_tgt_t decode(input logic [15:0] a,
                                                 input logic [7:0] cfg,
                                                 input logic wr,
                                                 input logic fl_en);
    logic [1:0] mode;
    mode = cfg[`XEMA_CFG_MODE_HI:`XEMA_CFG_MODE_LO];
    if (wr && fl_en)
      decode = xema_pkg::XEMA_TGT_FLASH;
    else if (cfg[`XEMA_CFG_FIFO_BIT] && a >= `XEMA_FIFO_LO && a <= `XEMA_FIFO_HI)
      decode = xema_pkg::XEMA_TGT_FIFO;
    else if (mode == `XEMA_MODE_ONCHIP)
      decode = xema_pkg::XEMA_TGT_RAM;
    else if (mode == `XEMA_MODE_OFFCHIP)
      decode = xema_pkg::XEMA_TGT_EXT;
    else if ({16'h0000, a} < 32'(RAM_BYTES))
      decode = xema_pkg::XEMA_TGT_RAM;
    else
      decode = xema_pkg::XEMA_TGT_EXT;
  endfunction : decode

  assign accept = req_in && (st_q == S_IDLE);
  assign acc_addr = eff_addr(req_data_in, ptr_hi_q, ptr_lo_q, page_q);
  assign acc_tgt = decode(acc_addr, cfg_q, req_data_in.wr, flash_en_q);

  // Register writes
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      page_q <= 8'h00;
      cfg_q <= `XEMA_CFG_RESET;
      ptr_hi_q <= 8'h00;
      ptr_lo_q <= 8'h00;
      flash_en_q <= 1'b0;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        `XEMA_REG_PAGE: page_q <= reg_wdata_in;
        `XEMA_REG_CFG: cfg_q <= reg_wdata_in & `XEMA_CFG_WMASK;
        `XEMA_REG_PTRH: ptr_hi_q <= reg_wdata_in;
        `XEMA_REG_PTRL: ptr_lo_q <= reg_wdata_in;
        `XEMA_REG_FLCTL: flash_en_q <= reg_wdata_in[`XEMA_FLCTL_WE_BIT];
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `XEMA_REG_PAGE: reg_rdata_out <= page_q;
        `XEMA_REG_CFG: reg_rdata_out <= cfg_q;
        `XEMA_REG_PTRH: reg_rdata_out <= ptr_hi_q;
        `XEMA_REG_PTRL: reg_rdata_out <= ptr_lo_q;
        `XEMA_REG_FLCTL: reg_rdata_out <= {7'h00, flash_en_q};
        `XEMA_REG_STAT: reg_rdata_out <= {3'h0, busy_out, tgt_q};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Access sequencing
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      st_q <= S_IDLE;
      addr_q <= 16'h0000;
      req_q <= '0;
      tgt_q <= xema_pkg::XEMA_TGT_RAM;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= (st_q == S_RESP);
      unique case (st_q)
        S_IDLE:
          if (req_in)
          begin
            addr_q <= acc_addr;
            req_q <= req_data_in;
            tgt_q <= acc_tgt;
            busy_out <= 1'b1;
            unique case (acc_tgt)
              xema_pkg::XEMA_TGT_FIFO: st_q <= S_FIFO;
              xema_pkg::XEMA_TGT_EXT: st_q <= S_EXT;
              default: st_q <= S_RESP;
            endcase
          end
        S_FIFO:
          if (fifo_ack_in)
            st_q <= S_RESP;
        S_EXT:
          if (ext_done)
            st_q <= S_RESP;
        S_RESP:
        begin
          busy_out <= 1'b0;
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // On-chip RAM
  always_ff @(posedge core_clk_in)
  begin
    if (accept && acc_tgt == xema_pkg::XEMA_TGT_RAM && req_data_in.wr)
      ram_q[acc_addr[RAW-1:0]] <= req_data_in.wdata;
  end

  // Read data from whichever target answered
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (accept && acc_tgt == xema_pkg::XEMA_TGT_RAM && !req_data_in.wr)
      rdata_out <= ram_q[acc_addr[RAW-1:0]];
    else if (st_q == S_FIFO && fifo_ack_in && !req_q.wr)
      rdata_out <= fifo_rdata_in;
    else if (st_q == S_EXT && ext_done && !req_q.wr)
      rdata_out <= ext_rdata;
  end

  // FIFO window request, held until the USB side acknowledges
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      fifo_req_out <= 1'b0;
      fifo_wr_out <= 1'b0;
      fifo_addr_out <= 10'h000;
      fifo_wdata_out <= 8'h00;
    end
    else if (accept && acc_tgt == xema_pkg::XEMA_TGT_FIFO)
    begin
      fifo_req_out <= 1'b1;
      fifo_wr_out <= req_data_in.wr;
      fifo_addr_out <= acc_addr[9:0];
      fifo_wdata_out <= req_data_in.wdata;
    end
    else if (fifo_ack_in)
      fifo_req_out <= 1'b0;
  end

  // Flash write pulse
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      flash_wr_out <= 1'b0;
      flash_addr_out <= 16'h0000;
      flash_data_out <= 8'h00;
    end
    else
    begin
      flash_wr_out <= accept && acc_tgt == xema_pkg::XEMA_TGT_FLASH;
      if (accept)
      begin
        flash_addr_out <= acc_addr;
        flash_data_out <= req_data_in.wdata;
      end
    end
  end

  // Off-chip cycle start
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      ext_start_q <= 1'b0;
    else
      ext_start_q <= accept && acc_tgt == xema_pkg::XEMA_TGT_EXT;
  end

  xema_xbus_seq #(
    .STROBE_CYC(STROBE_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_xbus (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(ext_start_q),
    .wr_in(req_q.wr),
    .mux_in(~cfg_q[`XEMA_CFG_NONMUX_BIT]),
    .ale_cyc_in(cfg_q[`XEMA_CFG_ALE_HI:`XEMA_CFG_ALE_LO]),
    .addr_in(addr_q),
    .wdata_in(req_q.wdata),
    .data_pin_in(data_pin_in),
    .pins_out(pins_out),
    .done_out(ext_done),
    .rdata_out(ext_rdata)
  );

  sequence fifo_launch;
    accept && acc_tgt == xema_pkg::XEMA_TGT_FIFO;
  endsequence

  sequence ram_launch;
    accept && acc_tgt == xema_pkg::XEMA_TGT_RAM;
  endsequence

  sequence ext_launch;
    accept && acc_tgt == xema_pkg::XEMA_TGT_EXT;
  endsequence

  chk_wide_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (accept && req_data_in.wide) |=> addr_q == {$past(ptr_hi_q), $past(ptr_lo_q)})
    else $error("wide form address mismatch");
  chk_page_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (accept && !req_data_in.wide) |=> addr_q == {$past(page_q), $past(req_data_in.index)})
    else $error("short form address mismatch");
  chk_ptr_lo_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == `XEMA_REG_PTRL) |=> ptr_lo_q == $past(reg_wdata_in))
    else $error("pointer low byte not stored");
  chk_ptr_hi_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == `XEMA_REG_PTRH) |=> ptr_hi_q == $past(reg_wdata_in))
    else $error("pointer high byte not stored");
  chk_flash_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (accept && !flash_en_q) |=> tgt_q != xema_pkg::XEMA_TGT_FLASH && !flash_wr_out)
    else $error("flash reached without write enable");
  chk_fifo_window: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (accept && !(req_data_in.wr && flash_en_q) && cfg_q[`XEMA_CFG_FIFO_BIT]
      && acc_addr >= `XEMA_FIFO_LO && acc_addr <= `XEMA_FIFO_HI)
      |=> tgt_q == xema_pkg::XEMA_TGT_FIFO && fifo_req_out)
    else $error("window access not sent to FIFO");
  chk_fifo_slow: assert property (@(posedge core_clk_in) disable iff (rst_in)
    fifo_launch |=> !done_out [*3])
    else $error("FIFO access finished too soon");
  chk_ram_done: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ram_launch |=> busy_out ##1 done_out)
    else $error("RAM access not answered in two cycles");
  chk_onchip_mode: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (accept && cfg_q[`XEMA_CFG_MODE_HI:`XEMA_CFG_MODE_LO] == `XEMA_MODE_ONCHIP)
      |=> ##1 !pins_out.ctl_oe)
    else $error("off-chip cycle in on-chip only mode");
  chk_fifo_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (fifo_req_out && !fifo_ack_in) |=> fifo_req_out)
    else $error("FIFO request dropped before acknowledge");
  chk_ext_own: assert property (@(posedge core_clk_in) disable iff (rst_in)
    pins_out.ctl_oe |-> st_q == S_EXT)
    else $error("pins owned outside an off-chip access");
  chk_ext_start: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ext_launch |=> ext_start_q ##1 pins_out.ctl_oe)
    else $error("off-chip access did not take the pins");
  chk_flash_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
    flash_wr_out |=> !flash_wr_out)
    else $error("flash write strobe longer than one cycle");
endmodule : xema_access

//--- tb/xema_sram_model.sv
// Behavioural off-chip SRAM hanging on the external interface pins
`timescale 1ns/1ps
module xema_sram_model (
  // Clock
  input wire logic core_clk_in,
  // Interface pins and bus wiring
  input wire xema_pkg::xema_pins_t pins_in,
  input wire logic mux_in,
  // Resolved data pin level
  output logic [7:0] data_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [15:0] addr;
  // Strobes sit on skipped pins, idle levels belong to port latches
  assign addr = mux_in ? {pins_in.addr[15:8], lat_q} : pins_in.addr;
  // Block drives, memory answers a read strobe, a released bus flips
  assign data_out = pins_in.data_oe ? pins_in.data :
                    (!pins_in.rd_n && pins_in.ctl_oe) ? mem[addr] : ~last_q;
  always_ff @(posedge core_clk_in)
  begin
    last_q <= data_out;
    if (pins_in.ale)
    begin
      lat_q <= data_out;
    end
    if (!pins_in.wr_n && pins_in.ctl_oe)
    begin
      mem[addr] <= data_out;
    end
  end
endmodule : xema_sram_model

//--- tb/tb.sv
// Self-checking bench for the external data space access block
`timescale 1ns/1ps
`include "xema_params.svh"
module tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic req_in = 1'b0;
  xema_pkg::xema_req_t req_data_in = '0;
  logic done_out, busy_out, fifo_req_out, fifo_wr_out, flash_wr_out;
  logic [7:0] rdata_out, fifo_wdata_out, flash_data_out, data_pin;
  logic [9:0] fifo_addr_out;
  logic [15:0] flash_addr_out;
  logic fifo_ack_in = 1'b0;
  logic [7:0] fifo_rdata_in = 8'h00;
  xema_pkg::xema_pins_t pins_out;
  logic mux_mode = 1'b1;
  logic [7:0] fmem [0:1023];
  logic [1:0] fwait = 2'h0;
  logic [9:0] f_addr = 10'h000;
  int fl_cnt = 0;
  logic [15:0] fl_addr = 16'h0000;
  logic [7:0] fl_data = 8'h00;
  logic [7:0] acc_rd;
  int acc_cyc;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [15:0] ea;
  logic [7:0] ed;
  logic [7:0] ext_cfg [0:3] = '{8'h0C, 8'h1F, 8'h05, 8'h1A};

  always #2.5 core_clk_in = ~core_clk_in;

  xema_access #(.RAM_BYTES(`XEMA_RAM_BYTES_4K), .STROBE_CYC(4), .HOLD_CYC(1)) uut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .req_in(req_in), .req_data_in(req_data_in),
    .done_out(done_out), .busy_out(busy_out), .rdata_out(rdata_out),
    .fifo_req_out(fifo_req_out), .fifo_wr_out(fifo_wr_out), .fifo_addr_out(fifo_addr_out),
    .fifo_wdata_out(fifo_wdata_out), .fifo_ack_in(fifo_ack_in), .fifo_rdata_in(fifo_rdata_in),
    .flash_wr_out(flash_wr_out), .flash_addr_out(flash_addr_out),
    .flash_data_out(flash_data_out), .data_pin_in(data_pin), .pins_out(pins_out));

  xema_sram_model mdl (.core_clk_in(core_clk_in), .pins_in(pins_out), .mux_in(mux_mode),
    .data_out(data_pin));

  // Stands in for the FIFO RAM on the core clock, acking on the third cycle of a request; only spare bytes used
  always @(posedge core_clk_in)
  begin
    fifo_ack_in <= 1'b0;
    fifo_rdata_in <= ~fifo_rdata_in;
    if (fifo_req_out === 1'b1 && !fifo_ack_in)
    begin
      fwait <= fwait + 2'h1;
      if (fwait == 2'h2)
      begin
        fwait <= 2'h0;
        fifo_ack_in <= 1'b1;
        fifo_rdata_in <= fmem[fifo_addr_out];
        f_addr <= fifo_addr_out;
        if (fifo_wr_out)
        begin
          fmem[fifo_addr_out] <= fifo_wdata_out;
        end
      end
    end
  end

  always @(posedge core_clk_in)
  begin
    if (flash_wr_out === 1'b1)
    begin
      fl_cnt <= fl_cnt + 1;
      fl_addr <= flash_addr_out;
      fl_data <= flash_data_out;
    end
  end

  // Pin ownership watch between clock edges
  always @(negedge core_clk_in)
  begin
    if (!rst_in && pins_out.rd_n === 1'b0 && pins_out.data_oe !== 1'b0)
    begin
      error_cnt++;
      $display("[ERR] data_oe expected 0 seen %b", pins_out.data_oe);
    end
    if (!rst_in && busy_out === 1'b0 && pins_out.addr_oe + pins_out.data_oe + pins_out.ctl_oe !== 2'h0)
    begin
      error_cnt++;
      $display("[ERR] idle_oe expected 0 seen 1");
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rw(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : rw

  task automatic rr(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, reg_rdata_out});
  endtask : rr

  task automatic acc(input logic wr, input logic wide, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge core_clk_in);
    req_in <= 1'b1;
    req_data_in <= {wr, wide, idx, wd};
    @(posedge core_clk_in);
    req_in <= 1'b0;
    acc_cyc = 0;
    do
    begin
      @(posedge core_clk_in);
      #1;
      acc_cyc++;
    end while (done_out !== 1'b1 && acc_cyc < 60);
    if (acc_cyc >= 60)
    begin
      chk("done", 16'h0001, 16'h0000);
    end
    acc_rd = rdata_out;
  endtask : acc

  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    rw(`XEMA_REG_PTRH, a[15:8]);
    rw(`XEMA_REG_PTRL, a[7:0]);
    acc(1'b1, 1'b1, 8'h00, d);
  endtask : xw

  task automatic xr(input logic [15:0] a, input logic [7:0] exp, input string nm);
    rw(`XEMA_REG_PTRH, a[15:8]);
    rw(`XEMA_REG_PTRL, a[7:0]);
    acc(1'b0, 1'b1, 8'h00, 8'h00);
    chk(nm, {8'h00, exp}, {8'h00, acc_rd});
  endtask : xr

  task automatic test_done();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial
  begin
    #50000;
    error_cnt++;
    test_done();
  end

  initial
  begin
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rr(`XEMA_REG_CFG, 8'h03, "cfg_rst");
    rr(`XEMA_REG_PAGE, 8'h00, "page_rst");
    rr(8'h10, 8'h00, "unmapped");
    rw(`XEMA_REG_CFG, 8'hFF);
    rr(`XEMA_REG_CFG, 8'h5F, "cfg_mask");
    rw(`XEMA_REG_CFG, 8'h00);
    rw(`XEMA_REG_PTRH, 8'h12);
    rw(`XEMA_REG_PTRL, 8'h34);
    rw(`XEMA_REG_PTRH, 8'h56);
    rr(`XEMA_REG_PTRH, 8'h56, "ptr_hi");
    rr(`XEMA_REG_PTRL, 8'h34, "ptr_lo");
    xw(16'h0123, 8'hA5);
    chk("ram_cyc", 16'h0001, 16'(acc_cyc));
    rr(`XEMA_REG_STAT, 8'h01, "stat_ram");
    rw(`XEMA_REG_PAGE, 8'h01);
    acc(1'b0, 1'b0, 8'h23, 8'h00);
    chk("short_rd", 16'h00A5, {8'h00, acc_rd});
    xw(16'h0FFF, 8'h5A);
    xr(16'h1FFF, 8'h5A, "ram_alias");
    xw(16'h03FF, 8'h33);
    xw(16'h07FF, 8'h44);
    xw(16'h0800, 8'h22);
    rw(`XEMA_REG_CFG, 8'h40);
    xw(16'h07FF, 8'h99);
    chk("fifo_addr", 16'h03FF, {6'h00, f_addr});
    chk("fifo_slow", 16'h0001, {15'h0000, acc_cyc > 2});
    rr(`XEMA_REG_STAT, 8'h02, "stat_fifo");
    xr(16'h07FF, 8'h99, "fifo_rd");
    xr(16'h0800, 8'h22, "above_win");
    xr(16'h03FF, 8'h33, "below_win");
    rw(`XEMA_REG_CFG, 8'h00);
    xr(16'h07FF, 8'h44, "ram_kept");
    rw(`XEMA_REG_FLCTL, 8'h01);
    xw(16'h0123, 8'h3C);
    chk("fl_cnt", 16'h0001, 16'(fl_cnt));
    chk("fl_addr", 16'h0123, fl_addr);
    chk("fl_data", 16'h003C, {8'h00, fl_data});
    rr(`XEMA_REG_STAT, 8'h08, "stat_flash");
    xr(16'h0123, 8'hA5, "fl_rd_data");
    rw(`XEMA_REG_FLCTL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ea = 16'h1234 + 16'(i) * 16'h1111;
      ed = 8'hC0 + 8'(i);
      rw(`XEMA_REG_CFG, ext_cfg[i]);
      mux_mode <= !ext_cfg[i][`XEMA_CFG_NONMUX_BIT];
      xw(ea, ed);
      rr(`XEMA_REG_STAT, 8'h04, "stat_ext");
      chk("ext_mem", {8'h00, ed}, {8'h00, mdl.mem[ea]});
      xr(ea, ed, "ext_rd");
      chk("ext_oe", 16'h0000, {13'h0000, pins_out.addr_oe, pins_out.data_oe, pins_out.ctl_oe});
    end
    test_done();
  end
endmodule : tb
